/* hdl/txseq_top.sv */
// Transmit start and host interface sequencing of the radio device:
// serial register and frame buffer access, start by pin or command,
// preamble and byte pacing, done and underrun events, clock output.
// Assumes sclk stands still outside selected accesses, clk runs free.
//
// Overview of operation
// - Frame loading and sending are separate and may overlap in time.
// - Start by trigger pin rising or TX start command while synth ready.
// - Frame-done pulse when the last frame byte has been sent.
// - Trigger rise starts the 176 us preamble and delimiter phase.
// - Underrun pulse when sending reaches bytes not yet written.
// - Clock output runs off, 1, 2, 4, 8 or 16 MHz by setting.
// - Synthesizer runs in synth ready and all transmit states.
module txseq_top
   import txseq_pkg::*;
#(
   parameter int DEPTH    = FB_DEPTH,
   parameter int PRE_CYC  = PREAMBLE_CYC,
   parameter int BYTE_CY  = BYTE_CYC
)(
   input  wire logic       clk,
   input  wire logic       rst_n,
   input  wire logic       clk_en,
   input  wire logic       sclk,
   input  wire logic       sel_n,
   input  wire logic       mosi,
   output      logic       miso_o,
   output      logic       miso_oe,
   input  wire logic       sleep_tx_trigger_pin,
   output      logic       frame_done_irq,
   output      logic       buffer_underrun_irq,
   output      logic       clock_out_pin,
   output      logic       synth_on,
   output      logic [7:0] tx_byte,
   output      logic       tx_byte_valid
);

   localparam int AW = $clog2(DEPTH);

   // Timer and counter widths bound the values that can be served
   if (DEPTH != 128 || PRE_CYC < 2 || BYTE_CY < 2 || PRE_CYC > 65535
       || BYTE_CY > 65535)
   begin : g_bad_param
      $error("txseq_top: unsupported parameter value");
   end

   function automatic logic [5:0] clkout_step(input logic [2:0] s);
      // Twice the output frequency in MHz: toggles per microsecond
      unique case (s)
         3'h1:    clkout_step = 6'h02;
         3'h2:    clkout_step = 6'h04;
         3'h3:    clkout_step = 6'h08;
         3'h4:    clkout_step = 6'h10;
         3'h5:    clkout_step = 6'h20;
         default: clkout_step = 6'h00;
      endcase
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // Serial link domain (sclk)
   logic       frm_rst_n;
   logic [2:0] bit_q;
   logic [6:0] sh_q;
   logic       got_cmd_q, first_q;
   logic [7:0] cmd_q, out_sh_q;
   logic [7:0] byte_in;
   logic       byte_done;
   spi_xfer_t  xfer_q;
   logic       tgl_q;
   logic [7:0] st_s1_q, st_s2_q;
   logic [2:0] ck_s1_q, ck_s2_q;
   logic [7:0] stat_q;
   logic [2:0] clkout_sel_q;
   logic [7:0] rd_val;

   // Frame state is cleared by the select line itself, not by an edge
   assign frm_rst_n = rst_n & ~sel_n;
   assign byte_in   = {sh_q, mosi};
   assign byte_done = (bit_q == 3'h7);
   assign rd_val    = (byte_in[5:0] == REG_STATE_CMD)   ? st_s2_q :
                      (byte_in[5:0] == REG_CLKOUT_CTRL) ? {5'h00, ck_s2_q} :
                      8'h00;

   // Bit and byte framing of one access
   always_ff @(posedge sclk or negedge frm_rst_n)
   begin
      if (!frm_rst_n)
      begin
         bit_q     <= 3'h0;
         sh_q      <= 7'h00;
         got_cmd_q <= 1'b0;
         first_q   <= 1'b0;
         cmd_q     <= 8'h00;
         out_sh_q  <= 8'h00;
      end
      else
      begin
         bit_q <= bit_q + 3'h1;
         sh_q  <= byte_in[6:0];
         if (byte_done && !got_cmd_q)
         begin
            got_cmd_q <= 1'b1;
            first_q   <= 1'b1;
            cmd_q     <= byte_in;
         end
         else if (byte_done)
            first_q <= 1'b0;
         if (byte_done && !got_cmd_q && byte_in[7:6] == ACC_REG_RD)
            out_sh_q <= rd_val;
         else
            out_sh_q <= {out_sh_q[6:0], 1'b0};
      end
   end

   // Read data leaves on the falling edge, sampled by the host rising
   always_ff @(negedge sclk or negedge frm_rst_n)
   begin
      if (!frm_rst_n)
      begin
         miso_o  <= 1'b0;
         miso_oe <= 1'b0;
      end
      else
      begin
         miso_o  <= out_sh_q[7];
         miso_oe <= got_cmd_q && (cmd_q[7:6] == ACC_REG_RD);
      end
   end

   // Byte hand-off: data held stable for a full byte time after toggle
   always_ff @(posedge sclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         xfer_q  <= '0;
         tgl_q   <= 1'b0;
         st_s1_q <= 8'h00;
         st_s2_q <= 8'h00;
         ck_s1_q <= 3'h0;
         ck_s2_q <= 3'h0;
      end
      else
      begin
         // Slow-changing status words; a torn value is read only mid-change
         st_s1_q <= stat_q;
         st_s2_q <= st_s1_q;
         ck_s1_q <= clkout_sel_q;
         ck_s2_q <= ck_s1_q;
         if (byte_done && got_cmd_q)
         begin
            xfer_q <= '{first: first_q, kind: cmd_q[7:6],
                        addr: cmd_q[5:0], data: byte_in};
            tgl_q  <= ~tgl_q;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Input synchronisers (clk)
   logic [2:0] tg_q, trg_q;
   logic       tg_seen_q, trg_lvl_q;
   logic       tg_seen_d, trg_lvl_d;
   logic       byte_ev, trig_rise;

   // A change counts once the second and third stages agree
   always_comb
   begin
      byte_ev   = (tg_q[1] == tg_q[2]) && (tg_q[2] != tg_seen_q);
      trig_rise = trg_q[1] && trg_q[2] && !trg_lvl_q;
      tg_seen_d = byte_ev ? tg_q[2] : tg_seen_q;
      trg_lvl_d = (trg_q[1] == trg_q[2]) ? trg_q[2] : trg_lvl_q;
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         tg_q      <= 3'h0;
         trg_q     <= 3'h0;
         tg_seen_q <= 1'b0;
         trg_lvl_q <= 1'b0;
      end
      else if (clk_en)
      begin
         tg_q      <= {tg_q[1:0], tgl_q};
         trg_q     <= {trg_q[1:0], sleep_tx_trigger_pin};
         tg_seen_q <= tg_seen_d;
         trg_lvl_q <= trg_lvl_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Transmit sequencer and frame buffer (clk)
   tx_state_t   state_q, state_d;
   logic [15:0] tmr_q, tmr_d;
   logic [AW:0] wr_cnt_q, wr_cnt_d;
   logic [AW:0] rd_idx_q, rd_idx_d;
   logic [7:0]  mem_q [DEPTH];
   logic        mem_we;
   logic [AW-1:0] mem_wa;
   logic [7:0]  stat_d, tx_byte_d;
   logic        done_d, ur_d, txv_d, start_req, reg_wr, fb_wr;
   logic [2:0]  clkout_sel_d;
   logic [AW:0] len;

   always_comb
   begin
      reg_wr    = byte_ev && xfer_q.kind == ACC_REG_WR;
      fb_wr     = byte_ev && xfer_q.kind == ACC_FB_WR;
      start_req = trig_rise || (reg_wr && xfer_q.addr == REG_STATE_CMD
                  && xfer_q.data == CMD_TX_START);
      len        = {1'b0, mem_q[0][AW-1:0]};
      state_d    = state_q;
      tmr_d      = tmr_q;
      rd_idx_d   = rd_idx_q;
      wr_cnt_d   = wr_cnt_q;
      done_d     = 1'b0;
      ur_d       = 1'b0;
      txv_d      = 1'b0;
      tx_byte_d  = tx_byte;
      clkout_sel_d = clkout_sel_q;
      mem_we     = 1'b0;
      mem_wa     = wr_cnt_q[AW-1:0];
      // Downloads are accepted in every state so they may overlap sending
      if (fb_wr && xfer_q.first)
      begin
         mem_we   = 1'b1;
         mem_wa   = '0;
         wr_cnt_d = (AW+1)'(1);
      end
      else if (fb_wr && !wr_cnt_q[AW])
      begin
         mem_we   = 1'b1;
         wr_cnt_d = wr_cnt_q + (AW+1)'(1);
      end
      if (reg_wr && xfer_q.addr == REG_CLKOUT_CTRL)
         clkout_sel_d = (xfer_q.data[2:0] > CLKOUT_MAX) ? CLKOUT_OFF
                                                        : xfer_q.data[2:0];
      unique case (state_q)
         ST_OFF:
            if (reg_wr && xfer_q.addr == REG_STATE_CMD
                && xfer_q.data == CMD_SYNTH_ON)
               state_d = ST_READY;
         ST_READY:
            if (start_req)
            begin
               state_d  = ST_PRE;
               tmr_d    = 16'(PRE_CYC - 1);
               rd_idx_d = '0;
            end
            else if (reg_wr && xfer_q.addr == REG_STATE_CMD
                     && xfer_q.data == CMD_OFF)
               state_d = ST_OFF;
         ST_PRE:
            // Start requests here and in ST_TX fall through unused
            if (tmr_q == 16'h0000)
            begin
               state_d = ST_TX;
               tmr_d   = 16'(BYTE_CY - 1);
            end
            else
               tmr_d = tmr_q - 16'h0001;
         ST_TX:
            if (tmr_q != 16'h0000)
               tmr_d = tmr_q - 16'h0001;
            else if (rd_idx_q >= wr_cnt_q)
            begin
               ur_d    = 1'b1;
               state_d = ST_READY;
            end
            else
            begin
               txv_d     = 1'b1;
               tx_byte_d = mem_q[rd_idx_q[AW-1:0]];
               rd_idx_d  = rd_idx_q + (AW+1)'(1);
               tmr_d     = 16'(BYTE_CY - 1);
               if (rd_idx_q >= len)
               begin
                  done_d  = 1'b1;
                  state_d = ST_READY;
               end
            end
      endcase
      unique case (state_d)
         ST_OFF:   stat_d = STAT_OFF;
         ST_READY: stat_d = STAT_READY;
         default:  stat_d = STAT_BUSY_TX;
      endcase
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         state_q             <= ST_OFF;
         tmr_q               <= 16'h0000;
         rd_idx_q            <= '0;
         wr_cnt_q            <= '0;
         stat_q              <= STAT_OFF;
         frame_done_irq      <= 1'b0;
         buffer_underrun_irq <= 1'b0;
         tx_byte_valid       <= 1'b0;
         tx_byte             <= 8'h00;
         synth_on            <= 1'b0;
         clkout_sel_q        <= CLKOUT_RESET;
         for (int i = 0; i < DEPTH; i++)
            mem_q[i] <= 8'h00;
      end
      else if (clk_en)
      begin
         state_q             <= state_d;
         tmr_q               <= tmr_d;
         rd_idx_q            <= rd_idx_d;
         wr_cnt_q            <= wr_cnt_d;
         stat_q              <= stat_d;
         frame_done_irq      <= done_d;
         buffer_underrun_irq <= ur_d;
         tx_byte_valid       <= txv_d;
         tx_byte             <= tx_byte_d;
         synth_on            <= (state_d != ST_OFF);
         clkout_sel_q        <= clkout_sel_d;
         if (mem_we)
            mem_q[mem_wa] <= xfer_q.data;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Clock output: phase accumulator, average rate exact, edges jitter
   logic [5:0] acc_q, acc_d;
   logic [6:0] acc_sum;
   logic       ck_out_d;

   always_comb
   begin
      acc_sum  = {1'b0, acc_q} + {1'b0, clkout_step(clkout_sel_q)};
      acc_d    = acc_sum[5:0];
      ck_out_d = clock_out_pin;
      if (clkout_sel_q == CLKOUT_OFF)
      begin
         acc_d    = 6'h00;
         ck_out_d = 1'b0;
      end
      else if (acc_sum >= {1'b0, CLK_MHZ_W})
      begin
         acc_d    = 6'(acc_sum - {1'b0, CLK_MHZ_W});
         ck_out_d = ~clock_out_pin;
      end
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         acc_q         <= 6'h00;
         clock_out_pin <= 1'b0;
      end
      else if (clk_en)
      begin
         acc_q         <= acc_d;
         clock_out_pin <= ck_out_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   sequence s_start_in_ready;
      clk_en && state_q == ST_READY && start_req;
   endsequence
   sequence s_pre_entered;
      state_q == ST_PRE && tmr_q == 16'(PRE_CYC - 1);
   endsequence

   property p_start_accept;
      s_start_in_ready |=> s_pre_entered;
   endproperty
   a_start_accept: assert property (p_start_accept)
      else $error("start in ready state not taken");

   property p_pre_to_tx;
      clk_en && state_q == ST_PRE && tmr_q == 16'h0000
      |=> state_q == ST_TX && tmr_q == 16'(BYTE_CY - 1);
   endproperty
   a_pre_to_tx: assert property (p_pre_to_tx)
      else $error("preamble phase did not end into sending");

   property p_done_pulse;
      frame_done_irq |-> $past(state_q) == ST_TX && state_q == ST_READY
                         && tx_byte_valid && !buffer_underrun_irq;
   endproperty
   a_done_pulse: assert property (p_done_pulse)
      else $error("frame done without final byte");

   property p_underrun;
      buffer_underrun_irq |-> $past(rd_idx_q) >= $past(wr_cnt_q)
                              && state_q == ST_READY && !tx_byte_valid;
   endproperty
   a_underrun: assert property (p_underrun)
      else $error("underrun without empty buffer");

   property p_ignore_busy;
      clk_en && (state_q == ST_PRE || state_q == ST_TX) && start_req
      |=> !(state_q == ST_PRE && tmr_q == 16'(PRE_CYC - 1));
   endproperty
   a_ignore_busy: assert property (p_ignore_busy)
      else $error("start request taken while busy");

   property p_overlap_load;
      clk_en && state_q == ST_TX && fb_wr && !xfer_q.first
      && !wr_cnt_q[AW] |=> wr_cnt_q == $past(wr_cnt_q) + (AW+1)'(1);
   endproperty
   a_overlap_load: assert property (p_overlap_load)
      else $error("download lost during sending");

   sequence s_clkout_off;
      clkout_sel_q == CLKOUT_OFF [*2];
   endsequence
   property p_clkout_off;
      s_clkout_off |-> !clock_out_pin;
   endproperty
   a_clkout_off: assert property (p_clkout_off)
      else $error("clock output toggles while off");

   // Flag and status readback must both follow the sequencer state
   property p_synth_on;
      synth_on == (state_q != ST_OFF)
      && stat_q == ((state_q == ST_OFF)   ? STAT_OFF :
                    (state_q == ST_READY) ? STAT_READY : STAT_BUSY_TX);
   endproperty
   a_synth_on: assert property (p_synth_on)
      else $error("synthesizer flag disagrees with state");

endmodule

/* hdl/txseq_pkg.sv */
// Constants and types shared by the transmit sequencing block.
// Assumes a 40 MHz system clock and a serial link clocked by the host.
package txseq_pkg;

   ////////////////////////////////////////////////////////////////////////
   // Register offsets (six-bit address field of the command byte)
   localparam logic [5:0] REG_STATE_CMD   = 6'h02;
   localparam logic [5:0] REG_CLKOUT_CTRL = 6'h03;

   // Access kinds in command byte bits 7:6
   localparam logic [1:0] ACC_FB_WR  = 2'h1;
   localparam logic [1:0] ACC_REG_RD = 2'h2;
   localparam logic [1:0] ACC_REG_WR = 2'h3;

   // Commands written to the state register, and state codes read back
   localparam logic [7:0] CMD_TX_START  = 8'h02;
   localparam logic [7:0] CMD_OFF       = 8'h08;
   localparam logic [7:0] CMD_SYNTH_ON  = 8'h09;
   localparam logic [7:0] STAT_OFF      = 8'h08;
   localparam logic [7:0] STAT_READY    = 8'h09;
   localparam logic [7:0] STAT_BUSY_TX  = 8'h02;

   // Clock output select: 0 off, 1..5 give 1, 2, 4, 8, 16 MHz
   localparam logic [2:0] CLKOUT_OFF   = 3'h0;
   localparam logic [2:0] CLKOUT_RESET = 3'h1;
   localparam logic [2:0] CLKOUT_MAX   = 3'h5;

   // Timing
   localparam int CLK_MHZ       = 40;
   localparam int PREAMBLE_US   = 176;
   localparam int BYTE_US       = 32;
   localparam int PREAMBLE_CYC  = PREAMBLE_US * CLK_MHZ;
   localparam int BYTE_CYC      = BYTE_US * CLK_MHZ;
   localparam logic [5:0] CLK_MHZ_W = 6'(CLK_MHZ);

   localparam int FB_DEPTH = 128;

   typedef enum logic [1:0] {ST_OFF, ST_READY, ST_PRE, ST_TX} tx_state_t;

   // One completed serial byte handed to the system clock domain
   typedef struct packed {
      logic       first;
      logic [1:0] kind;
      logic [5:0] addr;
      logic [7:0] data;
   } spi_xfer_t;

endpackage

/* testbench/host_model.sv */
// Host side model: serial link master and transmit trigger driver.
// Assumes the device samples mosi on rising sclk and drives miso on falling.
module host_model (
   input  wire logic clk,
   input  wire logic miso_o,
   input  wire logic miso_oe,
   output      logic sclk,
   output      logic sel_n,
   output      logic mosi,
   output      logic trig
);
   timeunit 1ns;
   timeprecision 100ps;

   // Link idle: clock low, deselected, trigger low
   initial
   begin
      sclk = 1'b0;
      sel_n = 1'b1;
      mosi = 1'b0;
      trig = 1'b0;
   end

   ////////////////////////////////////////////////////////////////////////
   // One byte, MSB first, 160 ns period keeps well under the clock limit
   task automatic xfer(input logic [7:0] w, output logic [7:0] r);
      for (int i = 7; i >= 0; i--)
      begin
         mosi = w[i];
         #80;
         sclk = 1'b1;
         r[i] = miso_oe & miso_o;
         #80;
         sclk = 1'b0;
      end
      #1000;
      mosi = ~w[0]; // Stale data never left on the line
   endtask

   // Select and deselect with the settle and idle gaps
   task automatic open_sel();
      sel_n = 1'b0;
      #250;
   endtask

   task automatic close_sel();
      #250;
      sel_n = 1'b1;
      #300;
   endtask

   // Trigger held four clocks, far above the minimum pulse width
   task automatic pulse_trig();
      @(posedge clk);
      #2 trig = 1'b1;
      repeat (4) @(posedge clk);
      #2 trig = 1'b0;
   endtask
endmodule

/* testbench/tb.sv */
// Self-checking bench for the transmit sequencing block.
// Assumes host_model drives the link; short preamble and byte counts.
module tb;
   import txseq_pkg::*;
   timeunit 1ns;
   timeprecision 100ps;

   localparam int PRE = 400;
   localparam int BYT = 128;

   logic clk, rst_n, clk_en, sclk, sel_n, mosi, miso_o, miso_oe, trig;
   logic frame_done_irq, buffer_underrun_irq, clock_out_pin, synth_on;
   logic tx_byte_valid, co_last;
   logic [7:0] tx_byte, v;
   logic [7:0] rxq[$];
   int fails, check_count, cyc, t_first, t_trig, n_done, n_ur, n_tog, n_both;

   txseq_top #(.PRE_CYC(PRE), .BYTE_CY(BYT)) u_txseq_top (
      .clk(clk), .rst_n(rst_n), .clk_en(clk_en), .sclk(sclk),
      .sel_n(sel_n), .mosi(mosi), .miso_o(miso_o), .miso_oe(miso_oe),
      .sleep_tx_trigger_pin(trig), .frame_done_irq(frame_done_irq),
      .buffer_underrun_irq(buffer_underrun_irq),
      .clock_out_pin(clock_out_pin), .synth_on(synth_on),
      .tx_byte(tx_byte), .tx_byte_valid(tx_byte_valid));

   host_model u_host_model (
      .clk(clk), .miso_o(miso_o), .miso_oe(miso_oe), .sclk(sclk),
      .sel_n(sel_n), .mosi(mosi), .trig(trig));

   // 40 MHz system clock
   initial
   begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end

   ////////////////////////////////////////////////////////////////////////
   // Monitor of sent bytes, events and clock output toggles
   always @(posedge clk)
   begin
      cyc++;
      if (tx_byte_valid === 1'b1)
      begin
         rxq.push_back(tx_byte);
         if (t_first < 0) t_first = cyc;
         if (frame_done_irq === 1'b1) n_both++;
      end
      if (frame_done_irq === 1'b1) n_done++;
      if (buffer_underrun_irq === 1'b1) n_ur++;
      if (clock_out_pin !== co_last) n_tog++;
      co_last = clock_out_pin;
   end

   ////////////////////////////////////////////////////////////////////////
   // Compare tasks: byte values and counts in a range
   task automatic chk8(input string n, input logic [7:0] e,
                       input logic [7:0] g);
      check_count++;
      if (g !== e)
      begin
         fails++;
         $display("[ERR] %s expected %h seen %h", n, e, g);
      end
   endtask

   task automatic chkn(input string n, input int lo, input int hi,
                       input int g);
      check_count++;
      if (g < lo || g > hi)
      begin
         fails++;
         $display("[ERR] %s expected %0d..%0d seen %0d", n, lo, hi, g);
      end
   endtask

   // Register access: command byte then one data byte
   task automatic rd(input logic [5:0] a, output logic [7:0] d);
      logic [7:0] x;
      u_host_model.open_sel();
      u_host_model.xfer({ACC_REG_RD, a}, x);
      u_host_model.xfer(8'h00, d);
      u_host_model.close_sel();
   endtask

   task automatic wr(input logic [5:0] a, input logic [7:0] d);
      logic [7:0] x;
      u_host_model.open_sel();
      u_host_model.xfer({ACC_REG_WR, a}, x);
      u_host_model.xfer(d, x);
      u_host_model.close_sel();
   endtask

   // Frame download: length byte then cnt payload bytes A0, A1, ...
   task automatic frame(input logic [7:0] len, input int cnt);
      logic [7:0] x;
      u_host_model.open_sel();
      u_host_model.xfer({ACC_FB_WR, 6'h00}, x);
      u_host_model.xfer(len, x);
      for (int k = 0; k < cnt; k++)
         u_host_model.xfer(8'(8'hA0 + k), x);
      u_host_model.close_sel();
   endtask

   task automatic clr();
      rxq.delete();
      n_done = 0;
      n_ur = 0;
      n_both = 0;
      t_first = -1;
   endtask

   // Bounded wait for the end of a frame, done or underrun
   task automatic wait_end();
      for (int i = 0; i < 4000 && n_done + n_ur == 0; i++)
         @(posedge clk);
      repeat (4) @(posedge clk);
      chkn("frame end seen", 1, 1, n_done + n_ur);
   endtask

   // Full three-payload frame with done on the last byte
   task automatic chk_frame();
      chkn("byte count", 4, 4, rxq.size());
      chkn("done with last byte", 1, 1, n_both);
      for (int k = 0; k < rxq.size() && k < 4; k++)
         chk8("sent byte", (k == 0) ? 8'h03 : 8'(8'hA0 + k - 1),
              rxq[k]);
      rd(REG_STATE_CMD, v);
      chk8("state after frame", STAT_READY, v);
   endtask

   task automatic give_verdict();
      $display("checks %0d mismatches %0d", check_count, fails);
      if (fails == 0 && check_count > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////
   // Watchdog, well beyond the few hundred microseconds of the tests
   initial
   begin
      #1000000;
      fails++;
      give_verdict();
   end

   // Test sequence
   initial
   begin
      rst_n = 1'b0;
      clk_en = 1'b1;
      co_last = 1'b0;
      clr();
      repeat (25) @(posedge clk);
      chk8("outputs in reset", 8'h00,
           {5'h0, synth_on, frame_done_irq, buffer_underrun_irq});
      #2 rst_n = 1'b1;
      rd(REG_STATE_CMD, v);
      chk8("state reset", STAT_OFF, v);
      rd(REG_CLKOUT_CTRL, v);
      chk8("clock select reset", {5'h0, CLKOUT_RESET}, v);
      rd(6'h3F, v);
      chk8("unmapped read", 8'h00, v);
      u_host_model.pulse_trig();
      repeat (PRE + 3 * BYT) @(posedge clk);
      chkn("bytes while off", 0, 0, rxq.size());
      chk8("synth off", 8'h00, {7'h0, synth_on});
      $display("test reset and off done");

      wr(REG_STATE_CMD, CMD_SYNTH_ON);
      chk8("synth ready", 8'h01, {7'h0, synth_on});
      clr();
      frame(8'h03, 3);
      wr(REG_STATE_CMD, CMD_TX_START);
      t_trig = cyc;
      u_host_model.pulse_trig();
      wait_end();
      chk_frame();
      chkn("busy start ignored", PRE + BYT - 64, PRE + BYT - 56,
           t_first - t_trig);
      $display("test command start done");

      clr();
      @(posedge clk);
      #2 t_trig = cyc;
      u_host_model.pulse_trig();
      frame(8'h03, 3);
      chk8("synth while sending", 8'h01, {7'h0, synth_on});
      rd(REG_STATE_CMD, v);
      chk8("state while sending", STAT_BUSY_TX, v);
      wait_end();
      chk_frame();
      chkn("first byte delay", PRE + BYT + 4, PRE + BYT + 8,
           t_first - t_trig);
      $display("test overlapped start done");

      clr();
      u_host_model.pulse_trig();
      frame(8'h03, 1);
      wait_end();
      chkn("underrun events", 1, 1, n_ur);
      chkn("done events", 0, 0, n_done);
      chkn("bytes before underrun", 2, 2, rxq.size());
      rd(REG_STATE_CMD, v);
      chk8("state after underrun", STAT_READY, v);
      wr(REG_STATE_CMD, CMD_OFF);
      rd(REG_STATE_CMD, v);
      chk8("state off again", STAT_OFF, v);
      chk8("synth off again", 8'h00, {7'h0, synth_on});
      $display("test underrun done");

      for (int s = 0; s <= 5; s++)
      begin
         wr(REG_CLKOUT_CTRL, 8'(s));
         n_tog = 0;
         repeat (400) @(posedge clk);
         chkn("clock toggles", (s == 0) ? 0 : (20 << (s - 1)) - 2,
              (s == 0) ? 0 : (20 << (s - 1)) + 2, n_tog);
      end
      // Enable low must freeze the clock output where it stands
      #2 clk_en = 1'b0;
      @(posedge clk);
      #2 n_tog = 0;
      repeat (40) @(posedge clk);
      chkn("clock frozen by enable", 0, 0, n_tog);
      #2 clk_en = 1'b1;
      wr(REG_CLKOUT_CTRL, 8'h06);
      rd(REG_CLKOUT_CTRL, v);
      chk8("clock select refused", {5'h0, CLKOUT_OFF}, v);
      $display("test clock output done");
      give_verdict();
   end
endmodule
